// ==== include/arbiter_defs.vh ====
// Purpose: Shared constants of the shared-bus arbiter.
// Assumes: Included by its bare name from the rtl files.
// Notes:   Definitions only, no logic.
`ifndef ARBITER_DEFS_VH
`define ARBITER_DEFS_VH

// Register byte offsets
`define CTRL_OFFSET       8'h00
`define STATUS_OFFSET     8'h04

// Control register fields and reset value
`define CTRL_YIELD_BIT    0
`define CTRL_RESET        32'h0000_0000

// Status register fields
`define STAT_STATE_LSB    0
`define STAT_NEED_BIT     2
`define STAT_HALT_BIT     3
`define STAT_REQ_BIT      4
`define STAT_BUSY_BIT     5
`define STAT_PRIO_BIT     6
`define STAT_COUNT_LSB    16

// Synchroniser depth
`define SYNC_STAGES       2

// Processor status codes (bit two, bit one, bit zero)
`define STATUS_INT_ACK    3'h0
`define STATUS_HALT       3'h3
`define STATUS_PASSIVE    3'h7

`endif

// ==== rtl/sync_bits.v ====
// Purpose: Two-stage synchroniser for a group of pin levels.
// Assumes: Each bit is an independent level.
// Notes:   The first stage is read only by the second.
`timescale 1ns/1ps
`include "arbiter_defs.vh"

module sync_bits #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clock_in,
  input  wire             arst_n_in,
  // Levels in and out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_one;  // Metastability catcher

  // Two flip-flops in a row
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stage_one <= {WIDTH{1'b1}};
      sync_out  <= {WIDTH{1'b1}};
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule // sync_bits

// ==== rtl/status_decode.v ====
// Purpose: Classifies the processor status code.
// Assumes: Status is already synchronised.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`include "arbiter_defs.vh"

module status_decode (
  // Status code
  input  wire [2:0] status_in,
  // Classification
  output reg        cycle_active_out,
  output reg        memory_cycle_out,
  output reg        halt_cycle_out,
  output reg        int_ack_out
);

  // Decode the code into cycle kinds
  always @* begin
    cycle_active_out = (status_in != `STATUS_PASSIVE);
    // Bit two high and not passive: memory command
    memory_cycle_out = status_in[2] && (status_in != `STATUS_PASSIVE);
    halt_cycle_out   = (status_in == `STATUS_HALT);
    int_ack_out      = (status_in == `STATUS_INT_ACK);
  end

endmodule // status_decode

// ==== rtl/bus_arbiter.v ====
// Purpose: Multiplexes one processor onto a shared multi-master bus.
// Assumes: All pins but the register bus are asynchronous to clock_in; bus clock is sampled.
// Notes:   Bus-side actions happen on falling edges of the bus clock; init resets the state at any clock_in edge.
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "arbiter_defs.vh"

//Contract
// R1 - Common-request lock blocks surrender to requesters
// R2 - Resident strap high uses select; else ignored
// R3 - Any-request strap yields to lower priority too
// R4 - Any-request: release after current bus cycle
// R5 - Request line low: release after each transfer
// R6 - On surrender drive bus request high
// R7 - Io strap: memory needs bus, io may release
// R8 - Interrupt acknowledge counts as io command
// R9 - Drive address enable for local drivers
// R10 - Init input resets; bus not held after
// R11 - Select high requests, low permits surrender
// R12 - Select stays clean from T2 to T4
// R13 - Request line tells of lower requesters
// R14 - Request line is shared open-drain
// R15 - Owner never pulls request line low
// R16 - Non-owner may pull request line low
// R17 - Owner releases when surrender conditions met
// R18 - Processor lock blocks every surrender
// R19 - Priority active: take bus at bus-clock fall
// R20 - Owner pulls busy low, releases when done
// R21 - Address enable active only while owning
// R22 - Any-request low: surrender per software table
module bus_arbiter #(
  parameter ADDR_WIDTH  = 8,
  parameter COUNT_WIDTH = 16
) (
  // Clock and reset
  input  wire                  clock_in,
  input  wire                  arst_n_in,
  // Register bus
  input  wire                  psel_in,
  input  wire                  penable_in,
  input  wire                  pwrite_in,
  input  wire [ADDR_WIDTH-1:0] paddr_in,
  input  wire [31:0]           pwdata_in,
  output reg  [31:0]           prdata_out,
  output reg                   pready_out,
  output reg                   pslverr_out,
  // Processor side
  input  wire [1:0]            proc_status_low_bits_in,
  input  wire                  proc_status_bit_two_in,
  input  wire                  proc_lock_n_in,
  input  wire                  system_or_local_select_in,
  output reg                   address_enable_n_out,
  // Straps
  input  wire                  resident_bus_strap_in,
  input  wire                  any_requester_strap_in,
  input  wire                  io_bus_strap_n_in,
  input  wire                  shared_request_lock_n_in,
  // Shared bus
  input  wire                  init_n_in,
  input  wire                  bus_clock_in,
  input  wire                  priority_in_n_in,
  input  wire                  shared_request_line_n_in,
  output reg                   shared_request_line_n_out,
  output reg                   shared_request_line_n_oen_out,
  input  wire                  busy_n_in,
  output reg                   busy_n_out,
  output reg                   busy_n_oen_out,
  output reg                   bus_request_out_n_out
);

  ////////////////////////////////////////////////////////////////////////
  // Arbiter states
  localparam [1:0] ST_IDLE = 2'b00;  // Bus not wanted, not held
  localparam [1:0] ST_REQ  = 2'b01;  // Waiting for priority and free bus
  localparam [1:0] ST_OWN  = 2'b10;  // Holding the shared bus

  ////////////////////////////////////////////////////////////////////////
  // Synchronised pins
  // Every pin, the bus clock too, is an async level to clock_in
  localparam SYNC_W = 14;

  wire [SYNC_W-1:0] raw_pins;   // Pins as they arrive
  wire [SYNC_W-1:0] pins;       // Pins after two flip-flops

  assign raw_pins = {bus_clock_in, proc_status_bit_two_in,
                     proc_status_low_bits_in, proc_lock_n_in,
                     system_or_local_select_in, resident_bus_strap_in,
                     any_requester_strap_in, io_bus_strap_n_in,
                     shared_request_lock_n_in, init_n_in,
                     priority_in_n_in, shared_request_line_n_in,
                     busy_n_in};

  sync_bits #(
    .WIDTH    (SYNC_W)
  ) u_sync (
    .clock_in (clock_in),
    .arst_n_in(arst_n_in),
    .async_in (raw_pins),
    .sync_out (pins)
  );

  // Sync flops reset high: status reads passive, so no false need
  wire       bclk_s     = pins[13];   // Bus clock level
  wire [2:0] status_s   = pins[12:10];// Processor status code
  wire       lock_n_s   = pins[9];    // Processor lock
  wire       select_s   = pins[8];    // System or local select
  wire       res_strap  = pins[7];    // Resident-bus strap
  wire       any_strap  = pins[6];    // Any-requester strap
  wire       io_strap_n = pins[5];    // Io-bus strap, active low
  wire       crq_lock_n = pins[4];    // Common-request lock
  wire       init_n_s   = pins[3];    // Shared initialise
  wire       prio_n_s   = pins[2];    // Priority in
  wire       creq_n_s   = pins[1];    // Common-request line
  wire       busy_n_s   = pins[0];    // Busy line

  ////////////////////////////////////////////////////////////////////////
  // Status classification
  wire cycle_active;  // Processor running a cycle
  wire memory_cycle;  // Memory command
  wire halt_cycle;    // Halt indication
  wire int_ack;       // Interrupt acknowledge

  status_decode u_decode (
    .status_in       (status_s),
    .cycle_active_out(cycle_active),
    .memory_cycle_out(memory_cycle),
    .halt_cycle_out  (halt_cycle),
    .int_ack_out     (int_ack)
  );

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg [1:0]             state;       // Arbiter state
  reg [1:0]             next_state;  // Following state
  reg                   bclk_prev;   // Bus clock one sample ago
  reg                   halted;      // Processor sits in halt
  reg [31:0]            ctrl;        // Software control
  reg [COUNT_WIDTH-1:0] grants;      // Acquisitions so far

  // Falling edge of the sampled bus clock
  wire bclk_fall = bclk_prev & ~bclk_s;

  ////////////////////////////////////////////////////////////////////////
  // Need for the shared bus in the current cycle
  reg need;  // This cycle must run on the shared bus

  always @* begin
    need = cycle_active & ~halt_cycle;
    // Io mode: only memory commands need the bus
    if (!io_strap_n)
      need = need & memory_cycle & ~int_ack;  // R7 R8
    // Resident mode: select decides, else select is ignored
    if (res_strap)
      need = need & select_s;  // R2 R11
  end

  ////////////////////////////////////////////////////////////////////////
  // Surrender decision for the owner
  reg window;    // Surrender may happen now
  reg forced;    // Higher priority took priority away
  reg yield_rq;  // Common request asks us to leave
  reg give_up;   // Give up the bus at this bus-clock fall

  always @* begin
    // End of the cycle, or a cycle that stays local
    window   = ~cycle_active | ~need;  // R4 R7 R11
    forced   = prio_n_s;
    // Any-request: any requester counts as a higher one
    // The common line is read here only as an input level
    if (any_strap)
      yield_rq = ~creq_n_s;  // R3 R5 R13
    else
      yield_rq = ~creq_n_s & ctrl[`CTRL_YIELD_BIT];  // R22 R13
    // Common-request lock only blocks request-driven surrender
    yield_rq = yield_rq & crq_lock_n;  // R1
    // Waiting for the window keeps a running transfer whole
    give_up  = window & (forced | yield_rq | halted);  // R17
    // Processor lock blocks every surrender
    if (!lock_n_s)
      give_up = 1'b0;  // R18
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (need)
          next_state = ST_REQ;
      end
      ST_REQ: begin
        if (!need)
          next_state = ST_IDLE;
        else if (!prio_n_s && busy_n_s)
          next_state = ST_OWN;  // R19
      end
      ST_OWN: begin
        if (give_up)
          next_state = ST_IDLE;  // R17
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register, stepped by bus-clock falls; init resets it
  // The bus clock is seen through the synchroniser, so each step
  // lags the pin's fall by about three clocks of clock_in
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state     <= ST_IDLE;
      bclk_prev <= 1'b1;
    end else begin
      bclk_prev <= bclk_s;
      if (!init_n_s)
        state <= ST_IDLE;  // R10
      else if (bclk_fall)
        state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Halt tracking: set by halt, cleared by any real cycle
  // A halt code wins over the clear when both are seen together
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      halted <= 1'b0;
    end else if (!init_n_s) begin
      halted <= 1'b0;
    end else if (halt_cycle) begin
      halted <= 1'b1;
    end else if (cycle_active) begin
      halted <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus-side outputs, one cycle after the state
  // Open-drain data stay low; only the enables move, so a released
  // pin never drives a high level onto a wired line
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_request_out_n_out         <= 1'b1;
      busy_n_out                    <= 1'b0;
      busy_n_oen_out                <= 1'b1;
      shared_request_line_n_out     <= 1'b0;
      shared_request_line_n_oen_out <= 1'b1;
      address_enable_n_out          <= 1'b1;
    end else begin
      // Request is high whenever the bus is given up
      bus_request_out_n_out <= (state == ST_IDLE);  // R6
      // Owner holds busy low, lets it float on release
      busy_n_out     <= 1'b0;
      busy_n_oen_out <= (state != ST_OWN);  // R20
      // Only a waiting non-owner pulls the common line
      shared_request_line_n_out     <= 1'b0;
      shared_request_line_n_oen_out <= (state != ST_REQ);  // R14 R15 R16
      // Local drivers enabled only while owning
      address_enable_n_out <= (state != ST_OWN);  // R9 R21
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Acquisition counter for software
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      grants <= {COUNT_WIDTH{1'b0}};
    end else if (bclk_fall && init_n_s &&
                 state == ST_REQ && next_state == ST_OWN) begin
      grants <= grants + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register bus slave: one wait state, write at the completing edge
  // Read data are loaded with pready, so they stand while it is high
  wire access = psel_in & penable_in;  // Access phase present

  // Is the address one of ours
  function is_mapped;
    input [ADDR_WIDTH-1:0] addr;
    begin
      is_mapped = (addr == `CTRL_OFFSET) || (addr == `STATUS_OFFSET);
    end
  endfunction

  // Status word assembly
  function [31:0] status_word;
    input [1:0]             st;
    input                   nd;
    input                   hl;
    input                   rq;
    input                   bz;
    input                   pr;
    input [COUNT_WIDTH-1:0] cnt;
    begin
      status_word = 32'h0000_0000;
      status_word[`STAT_STATE_LSB+1:`STAT_STATE_LSB] = st;
      status_word[`STAT_NEED_BIT] = nd;
      status_word[`STAT_HALT_BIT] = hl;
      status_word[`STAT_REQ_BIT]  = rq;
      status_word[`STAT_BUSY_BIT] = bz;
      status_word[`STAT_PRIO_BIT] = pr;
      status_word[`STAT_COUNT_LSB+COUNT_WIDTH-1:`STAT_COUNT_LSB] = cnt;
    end
  endfunction

  // Ready, read data and error for each access
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out <= access & ~pready_out;
      if (access && !pready_out) begin
        pslverr_out <= ~is_mapped(paddr_in);
        // Read data loaded together with ready
        if (paddr_in == `CTRL_OFFSET)
          prdata_out <= ctrl;
        else if (paddr_in == `STATUS_OFFSET)
          prdata_out <= status_word(state, need, halted, ~creq_n_s,
                                    ~busy_n_s, ~prio_n_s, grants);
        else
          prdata_out <= 32'h0000_0000;
      end else begin
        pslverr_out <= 1'b0;
      end
    end
  end

  // Control register write, only at the completing edge
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl <= `CTRL_RESET;
    end else if (access && pready_out && pwrite_in &&
                 paddr_in == `CTRL_OFFSET) begin
      ctrl <= {31'h0000_0000, pwdata_in[`CTRL_YIELD_BIT]};
    end
  end

endmodule // bus_arbiter

// ==== verification/bus_arbiter_monitor.sv ====
// Purpose: Assertions on the arbiter's bus-side pins.
// Assumes: Bound to bus_arbiter; one clock domain, clock_in.
// Notes:   Bounds allow two sync flops and one output flop.
`timescale 1ns/1ps
module bus_arbiter_monitor (
  // Clock and reset
  input wire clock_in,
  input wire arst_n_in,
  // Watched pins
  input wire proc_lock_n_in,
  input wire init_n_in,
  input wire bus_clock_in,
  input wire address_enable_n_out,
  input wire bus_request_out_n_out,
  input wire shared_request_line_n_out,
  input wire shared_request_line_n_oen_out,
  input wire busy_n_out,
  input wire busy_n_oen_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  //////////////////////////////////////////////////////////////////////////
  owner_no_pull_a: assert property (
    !address_enable_n_out |-> shared_request_line_n_oen_out)
    else $error("owner pulls the request line");
  busy_tracks_own_a: assert property (
    busy_n_oen_out == address_enable_n_out)
    else $error("busy pull differs from ownership");
  owner_requests_a: assert property (
    !address_enable_n_out |-> !bus_request_out_n_out)
    else $error("owner without bus request");
  release_drops_a: assert property (
    $rose(address_enable_n_out) |-> bus_request_out_n_out)
    else $error("bus request kept after surrender");
  pull_level_a: assert property (
    shared_request_line_n_out == 1'b0 && busy_n_out == 1'b0)
    else $error("open-drain pin drives high");
  lock_keeps_a: assert property (
    (!proc_lock_n_in && !address_enable_n_out && init_n_in) [*6]
    |=> !address_enable_n_out)
    else $error("bus surrendered under lock");
  init_frees_a: assert property (
    (!init_n_in) [*6] |=> address_enable_n_out && bus_request_out_n_out
      && busy_n_oen_out && shared_request_line_n_oen_out)
    else $error("bus held during initialise");
  req_before_own_a: assert property (
    $fell(address_enable_n_out) |-> $past(bus_request_out_n_out, 8) == 1'b0)
    else $error("bus taken without prior request");
  own_on_fall_a: assert property (
    $fell(address_enable_n_out) |-> !bus_clock_in)
    else $error("bus taken away from a bus clock fall");
endmodule // bus_arbiter_monitor

// ==== verification/peer_arbiters.sv ====
// Purpose: Peer arbiters, bus clock and pull-ups of the shared bus.
// Assumes: Bus clock runs free with a 160 ns period.
// Notes:   A peer holding priority also holds the busy line.
`timescale 1ns/1ps
module peer_arbiters (
  // Requests from the bench
  input  wire grant_in,
  input  wire peer_request_in,
  // Pins of the arbiter under test
  input  wire dut_busy_in,
  input  wire dut_busy_oen_in,
  input  wire dut_request_in,
  input  wire dut_request_oen_in,
  // Bus side levels
  output reg  bus_clock_out,
  output reg  priority_n_out,
  output wire busy_line_n_out,
  output wire request_line_n_out
);
  //////////////////////////////////////////////////////////////////////////
  // Free-running bus clock
  initial bus_clock_out = 1'b0;
  always #80 bus_clock_out = ~bus_clock_out;
  // Priority only moves on a bus clock rise
  initial priority_n_out = 1'b1;
  always @(posedge bus_clock_out) priority_n_out <= ~grant_in;
  // Pull-up wins unless a party pulls low
  assign busy_line_n_out = ~((~dut_busy_oen_in & ~dut_busy_in) |
                             priority_n_out);
  assign request_line_n_out = ~(peer_request_in |
                                (~dut_request_oen_in & ~dut_request_in));
endmodule // peer_arbiters

// ==== verification/tb_multi_master_bus_arbiter_straps.sv ====
// Purpose: Self-checking bench for the shared-bus arbiter.
// Assumes: Peer model makes the bus clock and wired lines.
// Notes:   Table rows test request decisions; hand tests follow.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fails++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_multi_master_bus_arbiter_straps;
  // Row: io strap, resident strap, select, status, request expected
  typedef struct packed {
    logic [5:0] drive;
    logic       exp;
  } row_t;
  logic        clock_in = 1'b0, arst_n_in = 1'b0;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, err, hit;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [2:0]  st = 3'h7;
  logic        lock_n = 1'b1, sel = 1'b0, res = 1'b0, any = 1'b0;
  logic        io_n = 1'b1, crql_n = 1'b1, init_n = 1'b1;
  logic        grant = 1'b0, peer_req = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, aen_n, req_n, crq_o, crq_oen, bsy_o;
  wire         bsy_oen, bclk, prio_n, busy_l, crq_l;
  int          fails = 0, checks_done = 0;
  row_t        rows [8] = '{7'h49, 7'h02, 7'h00, 7'h0b, 7'h68, 7'h79, 7'h32,
                            7'h46};
  //////////////////////////////////////////////////////////////////////////
  bus_arbiter i_bus_arbiter (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .proc_status_low_bits_in(st[1:0]),
    .proc_status_bit_two_in(st[2]), .proc_lock_n_in(lock_n),
    .system_or_local_select_in(sel), .address_enable_n_out(aen_n),
    .resident_bus_strap_in(res), .any_requester_strap_in(any),
    .io_bus_strap_n_in(io_n), .shared_request_lock_n_in(crql_n),
    .init_n_in(init_n), .bus_clock_in(bclk), .priority_in_n_in(prio_n),
    .shared_request_line_n_in(crq_l), .shared_request_line_n_out(crq_o),
    .shared_request_line_n_oen_out(crq_oen), .busy_n_in(busy_l),
    .busy_n_out(bsy_o), .busy_n_oen_out(bsy_oen),
    .bus_request_out_n_out(req_n));
  peer_arbiters i_peer_arbiters (
    .grant_in(grant), .peer_request_in(peer_req), .dut_busy_in(bsy_o),
    .dut_busy_oen_in(bsy_oen), .dut_request_in(crq_o),
    .dut_request_oen_in(crq_oen), .bus_clock_out(bclk),
    .priority_n_out(prio_n), .busy_line_n_out(busy_l),
    .request_line_n_out(crq_l));
  // 100 MHz clock
  always #5 clock_in = ~clock_in;
  // Verdict and end of run
  task end_of_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Wait for ownership (0) or request (1) to reach a level
  task automatic wait_for(input bit which, input logic v, input bit must,
                          output logic got);
    got = 1'b0;
    for (int n = 0; n < 80 && !got; n++) begin
      @(posedge clock_in);
      got = ((which ? req_n : aen_n) === v);
    end
    if (must && !got) begin
      fails++;
      $display("ERROR wait exp %h got %h", v, ~v);
      end_of_test;
    end
  endtask
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clock_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      $display("ERROR pready exp 1 got 0");
      end_of_test;
    end
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clock_in);
    arst_n_in <= 1'b1;
    `CHK("aen", 1'b1, aen_n)
    `CHK("req", 1'b1, req_n)
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    apb(1'b0, 8'h04, 32'h0);
    `CHK("state", 2'h0, rd[1:0])
    apb(1'b0, 8'h08, 32'h0);
    `CHK("slverr", 1'b1, err)
    $display("registers done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_in);
      {io_n, res, sel, st} <= rows[i].drive;
      wait_for(1'b1, 1'b0, rows[i].exp, hit);
      `CHK("request", rows[i].exp, hit)
      st <= 3'h7;
      init_n <= 1'b0;
      repeat (8) @(posedge clock_in);
      `CHK("init", 1'b1, req_n)
      init_n <= 1'b1;
      $display("row %0d done", i);
    end
    {io_n, res, st, grant} <= {1'b1, 1'b0, 3'h4, 1'b1};
    wait_for(1'b1, 1'b0, 1'b1, hit);
    `CHK("pull", 1'b0, crq_oen)
    wait_for(1'b0, 1'b0, 1'b1, hit);
    `CHK("busy", 1'b0, busy_l)
    `CHK("pull", 1'b1, crq_oen)
    {lock_n, grant, peer_req, any, st} <= 7'h1f;
    wait_for(1'b0, 1'b1, 1'b0, hit);
    `CHK("held", 1'b0, hit)
    lock_n <= 1'b1;
    wait_for(1'b0, 1'b1, 1'b1, hit);
    `CHK("req", 1'b1, req_n)
    $display("lock test done");
    {grant, peer_req, any, st} <= 6'h24;
    wait_for(1'b0, 1'b0, 1'b1, hit);
    {peer_req, st} <= 4'hf;
    wait_for(1'b0, 1'b1, 1'b0, hit);
    `CHK("yield", 1'b1, hit)
    apb(1'b1, 8'h00, 32'h0);
    {peer_req, any, st} <= {1'b0, 1'b1, 3'h4};
    wait_for(1'b0, 1'b0, 1'b1, hit);
    peer_req <= 1'b1;
    wait_for(1'b0, 1'b1, 1'b0, hit);
    `CHK("mid cycle", 1'b0, hit)
    {crql_n, st} <= 4'h7;
    wait_for(1'b0, 1'b1, 1'b0, hit);
    `CHK("crq lock", 1'b0, hit)
    crql_n <= 1'b1;
    wait_for(1'b0, 1'b1, 1'b0, hit);
    `CHK("yield", 1'b1, hit)
    $display("common request tests done");
    end_of_test;
  end
endmodule // tb_multi_master_bus_arbiter_straps
bind bus_arbiter bus_arbiter_monitor i_bus_arbiter_monitor (
  .clock_in(clock_in), .arst_n_in(arst_n_in),
  .proc_lock_n_in(proc_lock_n_in), .init_n_in(init_n_in),
  .bus_clock_in(bus_clock_in), .address_enable_n_out(address_enable_n_out),
  .bus_request_out_n_out(bus_request_out_n_out),
  .shared_request_line_n_out(shared_request_line_n_out),
  .shared_request_line_n_oen_out(shared_request_line_n_oen_out),
  .busy_n_out(busy_n_out), .busy_n_oen_out(busy_n_oen_out));
